// ### rtl/tfd_top.sv
// Purpose: trigger filter and done output, AXI4-Lite registers
// Assumes: inputs synchronous to CLK; settings image held by an outside store
// Notes:   lower CYCLES_PER_MS in simulation to shorten timing
`timescale 1ns/1ps
`default_nettype none
module tfd_top #(
    parameter int CYCLES_PER_MS = tfd_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // axi4-lite write address and data
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic [2:0]  S_AXI_AWPROT,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    // axi4-lite write response
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output logic [1:0]       S_AXI_BRESP,
    // axi4-lite read
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic [2:0]  S_AXI_ARPROT,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    // external contact inputs
    input  wire logic        EXT_TRIGGER_IN,
    input  wire logic        PANEL_LOCK_IN,
    // measurement engine
    input  wire logic        MEASURE_DONE_IN,
    output logic             MEASURE_START,
    // end-of-measurement output line, high means active
    output logic             MEASURE_DONE_OUT,
    // settings store
    input  wire logic        NV_LOAD_VALID,
    input  wire logic [31:0] NV_LOAD_DATA,
    output logic             NV_SAVE,
    output logic [31:0]      NV_SAVE_DATA
);
    tfd_pkg::tfd_state_type st;
    tfd_pkg::tfd_state_type next_st;

    logic qual_expired;
    logic pulse_expired;
    logic ext_trigger_in_qual;
    logic ext_trigger_in_event;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // offsets that answer OKAY
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == tfd_pkg::OFS_CTRL)  || (addr == tfd_pkg::OFS_QUAL) ||
                    (addr == tfd_pkg::OFS_PULSE) || (addr == tfd_pkg::OFS_STATUS) ||
                    (addr == tfd_pkg::OFS_FORCE);
    endfunction : is_mapped

    // clamp a ms setting to its range
    function automatic logic [8:0] clamp_ms(input logic [8:0] v, input logic [8:0] lo,
                                            input logic [8:0] hi);
        if (v < lo) begin
            clamp_ms = lo;
        end else if (v > hi) begin
            clamp_ms = hi;
        end else begin
            clamp_ms = v;
        end
    endfunction : clamp_ms

    // merge write data under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    // ----------------------------------------------------------------
    // timers
    // ----------------------------------------------------------------
    // qualifying timer runs only while the raw input stays on
    tfd_ms_timer #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_qual_timer (
        .clk     (CLK),
        .rst     (RST),
        .run     (EXT_TRIGGER_IN & st.filter_en),
        .len_ms  (st.qual_ms),
        .expired (qual_expired)
    );

    // pulse width timer runs while done is high in pulse mode
    tfd_ms_timer #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_pulse_timer (
        .clk     (CLK),
        .rst     (RST),
        .run     (st.done & st.pulse_mode),
        .len_ms  ({2'h0, st.pulse_ms}),
        .expired (pulse_expired)
    );

    // qualified trigger level and the selected start edge
    assign ext_trigger_in_qual  = st.filter_en ? (EXT_TRIGGER_IN & qual_expired)
                                     : EXT_TRIGGER_IN;
    assign ext_trigger_in_event = st.edge_off ? (st.ext_trigger_in_prev & ~ext_trigger_in_qual)
                                    : (~st.ext_trigger_in_prev & ext_trigger_in_qual);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] ctrl_word;
        logic [31:0] word;
        logic        do_write;
        ctrl_word = '0;
        word      = '0;
        do_write  = 1'b0;
        next_st   = st;
        next_st.start   = 1'b0;
        next_st.nv_save = 1'b0;

        // write address and data, taken in either order
        if (S_AXI_AWVALID && st.awready) begin
            next_st.aw_got  = 1'b1;
            next_st.awready = 1'b0;
            next_st.waddr   = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && st.wready) begin
            next_st.w_got  = 1'b1;
            next_st.wready = 1'b0;
            next_st.wdata  = S_AXI_WDATA;
            next_st.wstrb  = S_AXI_WSTRB;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            do_write       = 1'b1;
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = is_mapped(st.waddr) ? tfd_pkg::RESP_OKAY : tfd_pkg::RESP_SLVERR;
        end
        if (st.bvalid && S_AXI_BREADY) begin
            next_st.bvalid  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end

        // register writes
        ctrl_word[tfd_pkg::CTRL_FILTER_EN]  = st.filter_en;
        ctrl_word[tfd_pkg::CTRL_EDGE_OFF]   = st.edge_off;
        ctrl_word[tfd_pkg::CTRL_PULSE_MODE] = st.pulse_mode;
        ctrl_word[tfd_pkg::CTRL_TEST_MODE]  = st.test_mode;
        if (do_write) begin
            case (st.waddr)
                tfd_pkg::OFS_CTRL: begin
                    word = merge(ctrl_word, st.wdata, st.wstrb);
                    next_st.filter_en  = word[tfd_pkg::CTRL_FILTER_EN];
                    next_st.edge_off   = word[tfd_pkg::CTRL_EDGE_OFF];
                    next_st.pulse_mode = word[tfd_pkg::CTRL_PULSE_MODE];
                    next_st.test_mode  = word[tfd_pkg::CTRL_TEST_MODE];
                    next_st.nv_save    = 1'b1;
                end
                tfd_pkg::OFS_QUAL: begin
                    word = merge({23'h0, st.qual_ms}, st.wdata, st.wstrb);
                    next_st.qual_ms = (word[31:9] != '0) ? 9'(tfd_pkg::QUAL_MAX_MS) :
                        clamp_ms(word[8:0], 9'(tfd_pkg::QUAL_MIN_MS),
                                 9'(tfd_pkg::QUAL_MAX_MS));
                    next_st.nv_save = 1'b1;
                end
                tfd_pkg::OFS_PULSE: begin
                    word = merge({25'h0, st.pulse_ms}, st.wdata, st.wstrb);
                    next_st.pulse_ms = (word[31:9] != '0) ? 7'(tfd_pkg::PULSE_MAX_MS) :
                        7'(clamp_ms(word[8:0], 9'(tfd_pkg::PULSE_MIN_MS),
                                    9'(tfd_pkg::PULSE_MAX_MS)));
                    next_st.nv_save = 1'b1;
                end
                tfd_pkg::OFS_FORCE: begin
                    word = merge({31'h0, st.force_done}, st.wdata, st.wstrb);
                    next_st.force_done = word[tfd_pkg::FORCE_DONE];
                end
                default: begin
                end
            endcase
        end

        // restore stored settings at power-up
        if (NV_LOAD_VALID) begin
            next_st.filter_en  = NV_LOAD_DATA[tfd_pkg::NV_FILTER_EN];
            next_st.edge_off   = NV_LOAD_DATA[tfd_pkg::NV_EDGE_OFF];
            next_st.pulse_mode = NV_LOAD_DATA[tfd_pkg::NV_PULSE_MODE];
            next_st.qual_ms    = clamp_ms(NV_LOAD_DATA[tfd_pkg::NV_QUAL_LSB +: 9],
                                          9'(tfd_pkg::QUAL_MIN_MS), 9'(tfd_pkg::QUAL_MAX_MS));
            next_st.pulse_ms   = 7'(clamp_ms({2'h0, NV_LOAD_DATA[tfd_pkg::NV_PULSE_LSB +: 7]},
                                          9'(tfd_pkg::PULSE_MIN_MS), 9'(tfd_pkg::PULSE_MAX_MS)));
        end

        // settings image for the store
        next_st.nv_data = '0;
        next_st.nv_data[tfd_pkg::NV_FILTER_EN]      = next_st.filter_en;
        next_st.nv_data[tfd_pkg::NV_EDGE_OFF]       = next_st.edge_off;
        next_st.nv_data[tfd_pkg::NV_PULSE_MODE]     = next_st.pulse_mode;
        next_st.nv_data[tfd_pkg::NV_QUAL_LSB +: 9]  = next_st.qual_ms;
        next_st.nv_data[tfd_pkg::NV_PULSE_LSB +: 7] = next_st.pulse_ms;

        // read channel
        if (S_AXI_ARVALID && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rresp   = is_mapped(S_AXI_ARADDR) ? tfd_pkg::RESP_OKAY
                                                      : tfd_pkg::RESP_SLVERR;
            next_st.rdata   = '0;
            case (S_AXI_ARADDR)
                tfd_pkg::OFS_CTRL:  next_st.rdata = ctrl_word;
                tfd_pkg::OFS_QUAL:  next_st.rdata = {23'h0, st.qual_ms};
                tfd_pkg::OFS_PULSE: next_st.rdata = {25'h0, st.pulse_ms};
                tfd_pkg::OFS_FORCE: next_st.rdata = {31'h0, st.force_done};
                tfd_pkg::OFS_STATUS: begin
                    next_st.rdata[tfd_pkg::STAT_EXT_TRIGGER_IN_IN]   = EXT_TRIGGER_IN;
                    next_st.rdata[tfd_pkg::STAT_LOCK_IN]   = PANEL_LOCK_IN;
                    next_st.rdata[tfd_pkg::STAT_DONE_IN]   = MEASURE_DONE_IN;
                    next_st.rdata[tfd_pkg::STAT_DONE_OUT]  = st.done_pin;
                    next_st.rdata[tfd_pkg::STAT_EXT_TRIGGER_IN_QUAL] = ext_trigger_in_qual;
                end
                default: next_st.rdata = '0;
            endcase
        end
        if (st.rvalid && S_AXI_RREADY) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end

        // trigger start and done output; completion wins over any clear
        next_st.ext_trigger_in_prev = ext_trigger_in_qual;
        if (ext_trigger_in_event && !st.test_mode) begin
            next_st.start = 1'b1;
        end
        if (MEASURE_DONE_IN) begin
            next_st.done = 1'b1;
        end else if (!st.pulse_mode && ext_trigger_in_event) begin
            next_st.done = 1'b0;
        end else if (st.pulse_mode && pulse_expired) begin
            next_st.done = 1'b0;
        end
        next_st.done_pin = next_st.test_mode ? next_st.force_done : next_st.done;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st          <= '0;
            st.awready  <= 1'b1;
            st.wready   <= 1'b1;
            st.arready  <= 1'b1;
            st.qual_ms  <= tfd_pkg::QUAL_RESET;
            st.pulse_ms <= tfd_pkg::PULSE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign S_AXI_AWREADY    = st.awready;
    assign S_AXI_WREADY     = st.wready;
    assign S_AXI_BVALID     = st.bvalid;
    assign S_AXI_BRESP      = st.bresp;
    assign S_AXI_ARREADY    = st.arready;
    assign S_AXI_RVALID     = st.rvalid;
    assign S_AXI_RDATA      = st.rdata;
    assign S_AXI_RRESP      = st.rresp;
    assign MEASURE_START    = st.start;
    assign MEASURE_DONE_OUT = st.done_pin;
    assign NV_SAVE          = st.nv_save;
    assign NV_SAVE_DATA     = st.nv_data;
endmodule : tfd_top
`default_nettype wire

// ### inc/tfd_pkg.sv
// Purpose: shared constants and types of tfd
// Assumes: 100 MHz clock, AXI4-Lite register access with 32-bit data
// Notes:   times kept in ms, converted to cycles
package tfd_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int MS_IN_NS       = 1000000;
    localparam int CYCLES_PER_MS  = MS_IN_NS / CLK_PERIOD_NS;
    localparam int QUAL_MIN_MS    = 1;
    localparam int QUAL_MAX_MS    = 500;
    localparam int PULSE_MIN_MS   = 1;
    localparam int PULSE_MAX_MS   = 100;

    // ----------------------------------------------------------------
    // register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_QUAL   = 8'h04;
    localparam logic [7:0] OFS_PULSE  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_FORCE  = 8'h10;

    // control register fields
    localparam int CTRL_FILTER_EN  = 0;
    localparam int CTRL_EDGE_OFF   = 1;
    localparam int CTRL_PULSE_MODE = 2;
    localparam int CTRL_TEST_MODE  = 3;
    // status register fields
    localparam int STAT_EXT_TRIGGER_IN_IN    = 0;
    localparam int STAT_LOCK_IN    = 1;
    localparam int STAT_DONE_IN    = 2;
    localparam int STAT_DONE_OUT   = 3;
    localparam int STAT_EXT_TRIGGER_IN_QUAL  = 4;
    // force register field
    localparam int FORCE_DONE      = 0;

    // reset values
    localparam logic [8:0] QUAL_RESET  = 9'h001;
    localparam logic [6:0] PULSE_RESET = 7'h0A;

    // settings image in the store
    localparam int NV_FILTER_EN  = 0;
    localparam int NV_EDGE_OFF   = 1;
    localparam int NV_PULSE_MODE = 2;
    localparam int NV_QUAL_LSB   = 4;
    localparam int NV_PULSE_LSB  = 13;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // state of the top module
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        filter_en;
        logic        edge_off;
        logic        pulse_mode;
        logic        test_mode;
        logic        force_done;
        logic [8:0]  qual_ms;
        logic [6:0]  pulse_ms;
        logic        ext_trigger_in_prev;
        logic        done;
        logic        done_pin;
        logic        start;
        logic        nv_save;
        logic [31:0] nv_data;
    } tfd_state_type;

    // state of the millisecond timer
    typedef struct packed {
        logic [31:0] presc;
        logic [8:0]  ms;
        logic        expired;
    } tfd_timer_type;
endpackage : tfd_pkg

// ### rtl/tfd_ms_timer.sv
// Purpose: millisecond timer for qualifying and pulse width
// Assumes: len_ms is at least one
// Notes:   counting restarts from zero whenever run drops
`timescale 1ns/1ps
`default_nettype none
module tfd_ms_timer #(
    parameter int CYCLES_PER_MS = tfd_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic [8:0] len_ms,
    // result
    output logic            expired
);
    tfd_pkg::tfd_timer_type st;
    tfd_pkg::tfd_timer_type next_st;

    // count ms while run is held, then flag expiry
    always_comb begin
        next_st = st;
        if (!run) begin
            next_st = '0;
        end else if (!st.expired) begin
            if (st.presc == 32'(CYCLES_PER_MS - 1)) begin
                next_st.presc = '0;
                next_st.ms    = st.ms + 9'h001;
                if (st.ms + 9'h001 == len_ms) begin
                    next_st.expired = 1'b1;
                end
            end else begin
                next_st.presc = st.presc + 32'h00000001;
            end
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expired = st.expired;
endmodule : tfd_ms_timer
`default_nettype wire

// ### sim/tfd_top_sva.sv
// Purpose: port checks of tfd_top
// Assumes: AWADDR stands while W is taken
// Notes:   mode and width mirrored from writes and loads
`timescale 1ns/1ps
`default_nettype none
module tfd_top_sva #(
    parameter int CYCLES_PER_MS = tfd_pkg::CYCLES_PER_MS
) (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST,
    // bus
    input wire logic [7:0]  S_AXI_AWADDR,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [31:0] S_AXI_RDATA,
    // measurement and settings store
    input wire logic        MEASURE_DONE_IN,
    input wire logic        MEASURE_START,
    input wire logic        MEASURE_DONE_OUT,
    input wire logic        NV_LOAD_VALID,
    input wire logic [31:0] NV_LOAD_DATA,
    input wire logic        NV_SAVE
);
    logic        tm;
    logic        pm;
    logic [6:0]  pw;
    logic [31:0] hi_cnt;
    logic        wr;
    assign wr = S_AXI_WVALID && S_AXI_WREADY;
    // mirror of test mode, pulse mode, width and the length of the current high run
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tm     <= 1'b0;
            pm     <= 1'b0;
            pw     <= tfd_pkg::PULSE_RESET;
            hi_cnt <= 32'h0;
        end else begin
            if (wr && S_AXI_AWADDR == tfd_pkg::OFS_CTRL) begin
                tm <= S_AXI_WDATA[3];
                pm <= S_AXI_WDATA[2];
            end
            if (wr && S_AXI_AWADDR == tfd_pkg::OFS_PULSE) pw <= S_AXI_WDATA[6:0];
            if (NV_LOAD_VALID) begin
                pm <= NV_LOAD_DATA[2];
                pw <= NV_LOAD_DATA[19:13];
            end
            hi_cnt <= MEASURE_DONE_OUT ? hi_cnt + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_done_set;
        MEASURE_DONE_IN && !tm |=> MEASURE_DONE_OUT;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done not raised");
    property p_pulse_len;
        pm && !tm && $fell(MEASURE_DONE_OUT) |-> hi_cnt == pw * CYCLES_PER_MS + 1;
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("pulse width wrong");
    property p_pulse_max;
        pm && !tm |-> hi_cnt <= pw * CYCLES_PER_MS + 1;
    endproperty
    a_pulse_max: assert property (p_pulse_max)
        else $error("pulse not ended in time");
    property p_hold_clear;
        !pm && !tm && $fell(MEASURE_DONE_OUT) |->
            (##[0:2] MEASURE_START) or ($past(MEASURE_START) || $past(MEASURE_START, 2));
    endproperty
    a_hold_clear: assert property (p_hold_clear)
        else $error("held done dropped untriggered");
    property p_start_test;
        tm && $past(tm) |-> !MEASURE_START;
    endproperty
    a_start_test: assert property (p_start_test)
        else $error("start issued in test mode");
    property p_b_stand;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_stand: assert property (p_b_stand)
        else $error("write response not held");
    property p_r_stand;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_stand: assert property (p_r_stand)
        else $error("read data not held");
    property p_save_b;
        NV_SAVE |-> S_AXI_BVALID;
    endproperty
    a_save_b: assert property (p_save_b)
        else $error("save outside write answer");
    // main scenarios reached
    c_pulse: cover property (pm && $fell(MEASURE_DONE_OUT));
    c_hold: cover property (!pm && $fell(MEASURE_DONE_OUT));
    c_save: cover property (NV_SAVE);
endmodule : tfd_top_sva
`default_nettype wire

// ### sim/tfd_ext_ctrl.sv
// Purpose: outside controller closing the trigger and lock contacts
// Assumes: levels set by the bench
// Notes:   contacts lag commands by one clock
`timescale 1ns/1ps
`default_nettype none
module tfd_ext_ctrl (
    // clock
    input wire logic clk,
    // commands
    input wire logic ext_trigger_in_cmd,
    input wire logic lock_cmd,
    // contact lines
    output logic     ext_trigger_in,
    output logic     lock
);
    initial ext_trigger_in = 1'b0;
    initial lock = 1'b0;
    // contacts follow the commands one clock late
    always @(posedge clk) begin
        ext_trigger_in <= ext_trigger_in_cmd;
        lock <= lock_cmd;
    end
endmodule : tfd_ext_ctrl
`default_nettype wire

// ### sim/tb_top.sv
// Purpose: self-checking bench of tfd_top
// Assumes: 1 ms shortened to 10 clocks
// Notes:   engine model answers each start with a done pulse while eng_on is set
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int CPM = 10;
    logic        clk = 0, rst = 1, ext_trigger_in_cmd = 0, lock_cmd = 0, ext_trigger_in, lock;
    logic        awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
    logic        arvalid = 0, arready, rvalid, rready = 0, nv_ld = 0;
    logic        done_in = 0, start, done_out, nv_save, eng_on = 1;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, nv_data = 0, nv_sdata, starts = 0, s;
    logic [1:0]  bresp, rresp;
    int          fail_count = 0, comparisons = 0, eng_cnt = 0;
    always #5 clk = ~clk;
    tfd_top #(.CYCLES_PER_MS(CPM)) u_tfd_top (.CLK(clk), .RST(rst),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .EXT_TRIGGER_IN(ext_trigger_in), .PANEL_LOCK_IN(lock),
        .MEASURE_DONE_IN(done_in), .MEASURE_START(start), .MEASURE_DONE_OUT(done_out),
        .NV_LOAD_VALID(nv_ld), .NV_LOAD_DATA(nv_data), .NV_SAVE(nv_save),
        .NV_SAVE_DATA(nv_sdata));
    tfd_ext_ctrl u_tfd_ext_ctrl (.clk(clk), .ext_trigger_in_cmd(ext_trigger_in_cmd), .lock_cmd(lock_cmd),
        .ext_trigger_in(ext_trigger_in), .lock(lock));
    // engine model: counts starts, done pulse 20 clocks later
    always @(posedge clk) begin
        done_in <= 1'b0;
        if (!rst) starts <= starts + {31'h0, start};
        if (start && eng_on) eng_cnt <= 20;
        else if (eng_cnt > 1) eng_cnt <= eng_cnt - 1;
        else if (eng_cnt == 1) begin
            eng_cnt <= 0;
            done_in <= 1'b1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one bus write; bready raised late
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit b;
        b = 0;
        @(posedge clk);
        awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d;
        for (int n = 0; n < 40 && !b; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bready && bvalid) begin
                b = 1;
                chk(bresp, er);
                bready <= 0;
            end else if (n == 2) bready <= 1;
        end
        chk({31'h0, b}, 32'h1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        bit b;
        b = 0;
        @(posedge clk);
        arvalid <= 1; araddr <= a;
        for (int n = 0; n < 40 && !b; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
            if (rready && rvalid) begin
                b = 1;
                chk(rdata, e);
                chk(rresp, er);
                rready <= 0;
            end else if (n == 2) rready <= 1;
        end
        chk({31'h0, b}, 32'h1);
    endtask : rd
    task automatic tg(input logic v, input int n);
        ext_trigger_in_cmd <= v;
        repeat (n) @(posedge clk);
    endtask : tg
    task automatic wait_out(input logic v);
        for (int n = 0; n < 300 && done_out !== v; n++) @(posedge clk);
        chk(done_out, v);
    endtask : wait_out
    task automatic t_regs;
        rd(tfd_pkg::OFS_CTRL, 32'h0, 2'h0);
        rd(tfd_pkg::OFS_QUAL, 32'h1, 2'h0);
        rd(tfd_pkg::OFS_PULSE, 32'h0A, 2'h0);
        rd(8'h14, 32'h0, 2'h2);
        wr(8'h14, 32'hFF, 2'h2);
        $display("test regs done");
    endtask : t_regs
    task automatic t_edge;
        s = starts;
        tg(1, 10);
        chk(starts - s, 32'h1);
        wait_out(1);
        tg(0, 10);
        chk(starts - s, 32'h1);
        chk(done_out, 1);
        wr(tfd_pkg::OFS_CTRL, 32'h2, 2'h0);
        tg(1, 10);
        chk(starts - s, 32'h1);
        tg(0, 10);
        chk(starts - s, 32'h2);
        chk(done_out, 0);
        wait_out(1);
        $display("test edge done");
    endtask : t_edge
    task automatic t_filter;
        wr(tfd_pkg::OFS_CTRL, 32'h1, 2'h0);
        s = starts;
        tg(1, 5);
        tg(0, 10);
        chk(starts - s, 32'h0);
        tg(1, 20);
        chk(starts - s, 32'h1);
        tg(0, 5);
        wait_out(1);
        $display("test filter done");
    endtask : t_filter
    task automatic t_hold;
        wr(tfd_pkg::OFS_CTRL, 32'h0, 2'h0);
        repeat (100) @(posedge clk);
        chk(done_out, 1);
        eng_on <= 0;
        tg(1, 10);
        chk(done_out, 0);
        tg(0, 10);
        eng_on <= 1;
        $display("test hold done");
    endtask : t_hold
    task automatic t_pulse;
        int c;
        c = 0;
        wr(tfd_pkg::OFS_CTRL, 32'h4, 2'h0);
        wr(tfd_pkg::OFS_PULSE, 32'h1, 2'h0);
        chk(nv_sdata, 32'h2014);
        tg(1, 5);
        wait_out(1);
        while (done_out === 1'b1 && c < 500) begin
            @(posedge clk);
            c++;
        end
        chk(c, CPM + 1);
        tg(0, 5);
        $display("test pulse done");
    endtask : t_pulse
    task automatic t_nv;
        @(posedge clk);
        nv_data <= 32'h6053;
        nv_ld <= 1;
        @(posedge clk);
        nv_ld <= 0;
        rd(tfd_pkg::OFS_CTRL, 32'h3, 2'h0);
        rd(tfd_pkg::OFS_QUAL, 32'h5, 2'h0);
        rd(tfd_pkg::OFS_PULSE, 32'h3, 2'h0);
        $display("test store done");
    endtask : t_nv
    task automatic t_test;
        wr(tfd_pkg::OFS_CTRL, 32'h8, 2'h0);
        wr(tfd_pkg::OFS_FORCE, 32'h1, 2'h0);
        s = starts;
        lock_cmd <= 1;
        tg(1, 10);
        chk(done_out, 1);
        rd(tfd_pkg::OFS_STATUS, 32'h1B, 2'h0);
        chk(starts - s, 32'h0);
        wr(tfd_pkg::OFS_FORCE, 32'h0, 2'h0);
        repeat (2) @(posedge clk);
        chk(done_out, 0);
        $display("test mode done");
    endtask : t_test
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_regs;
        t_edge;
        t_filter;
        t_hold;
        t_pulse;
        t_nv;
        t_test;
        give_verdict;
    end
    // watchdog cuts a hang short
    initial begin
        #200000;
        fail_count++;
        give_verdict;
    end
endmodule : tb_top
bind tfd_top tfd_top_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_tfd_top_sva (.CLK(CLK),
    .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .MEASURE_DONE_IN(MEASURE_DONE_IN), .MEASURE_START(MEASURE_START),
    .MEASURE_DONE_OUT(MEASURE_DONE_OUT), .NV_LOAD_VALID(NV_LOAD_VALID),
    .NV_LOAD_DATA(NV_LOAD_DATA), .NV_SAVE(NV_SAVE));
`default_nettype wire
